//--- hw/vjd_pkg.sv
// package: types and constants of the voltage vector jump detector
package vjd_pkg;
  localparam int SAMPLES_PER_CYCLE = 64;
  localparam int HIST_AW           = 6;
  localparam int NUM_CH            = 4;
  localparam int NUM_CAND          = 7;
  localparam int CLK_MHZ           = 100;
  localparam int PULSE_MS          = 20;
  localparam int PULSE_CYCLES      = PULSE_MS * 1000 * CLK_MHZ;
  localparam int CNT_W             = 22;
  localparam logic [15:0] THR_DEFAULT   = 16'h01f4; // 5.00 deg
  localparam logic [13:0] UV_DEFAULT    = 14'h251c; // 95.00 %
  localparam logic [63:0] PCT_SCALE_SQ  = 64'h0000_0000_05f5_e100; // 10000^2
  localparam logic [63:0] TAN_Q20       = 64'h0000_0000_0000_00b7; // pi/18000
  localparam int          TAN_SHIFT     = 20;
  localparam int          IDX_PE1       = 0;
  localparam int          IDX_PP12      = 3;
  localparam int          IDX_U4        = 6;
  localparam logic [6:0]  MASK_PE       = 7'h07;
  localparam logic [6:0]  MASK_PP       = 7'h38;

  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } vjd_cplx_t;

  typedef struct packed {
    logic signed [16:0] re;
    logic signed [16:0] im;
  } vjd_wcplx_t;

  typedef enum logic [1:0] {
    ST_NORMAL, ST_BLOCKED, ST_TRIP, ST_ALARM
  } vjd_status_t;

  typedef enum logic [0:0] { AV_TRIP, AV_TRIP_ALARM } vjd_avail_t;

  typedef enum logic [3:0] {
    MON_ALL_PP, MON_ANY_PP, MON_L12, MON_L23, MON_L31,
    MON_ALL_PE, MON_ANY_PE, MON_L1, MON_L2, MON_L3, MON_U4
  } vjd_mon_t;
endpackage

//--- hw/vjd_detector.sv
// module: single-stage islanding detector on voltage vector angle jumps
`timescale 1ns/1ps

// Summary of operation
// - one operating stage only, meant for instantaneous tripping
// - selected channels tracked at 64 samples per fundamental cycle
// - each channel handled as a complex vector, never magnitude only
// - pick-up only when angle change reaches the angle-step threshold
// - trip output lasts 20 ms and then drops by itself
// - one threshold applies identically to all monitored channels
// - thresholds follow the active setting group, changeable while running
// - force, stage and channel settings are static general settings
// - force status overrides state, only with forcing enabled
// - alarm path works only when trip plus alarm is selected
// - monitored-voltage selects channel set, default any phase-to-phase
// - trip threshold lead or lag, 0.01 deg steps, default 5 deg
// - separate alarm threshold, lead or lag, default 5 deg
// - detector blocked while voltage below undervoltage limit
// - angle change compares present vector with the one 20 ms earlier
// - block input sampled each program cycle, blocked instead of trip
module vjd_detector #(
  parameter int PULSE_LEN = vjd_pkg::PULSE_CYCLES
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 clk_en,
  input  wire logic                 sample_valid,
  input  vjd_pkg::vjd_cplx_t        chan1_complex_vector,
  input  vjd_pkg::vjd_cplx_t        chan2_complex_vector,
  input  vjd_pkg::vjd_cplx_t        chan3_complex_vector,
  input  vjd_pkg::vjd_cplx_t        chan4_complex_vector,
  input  wire logic [15:0]          nominal_voltage,
  input  wire logic [15:0]          trip_threshold,
  input  wire logic [15:0]          alarm_threshold,
  input  wire logic [13:0]          uv_limit,
  input  wire logic                 block_in,
  input  wire logic                 force_enable,
  input  vjd_pkg::vjd_status_t      force_status,
  input  vjd_pkg::vjd_avail_t       stage_avail,
  input  vjd_pkg::vjd_mon_t         monitored,
  output logic                      trip,
  output logic                      alarm,
  output logic                      blocked,
  output vjd_pkg::vjd_status_t      status,
  output logic [6:0]                fault_channels
);

  // squared magnitude of a widened vector
  function automatic logic [63:0] mag2(input vjd_pkg::vjd_wcplx_t v);
    logic signed [63:0] r;
    logic signed [63:0] i;
    r = 64'(v.re);
    i = 64'(v.im);
    mag2 = 64'(r * r + i * i);
  endfunction

  // angle step between past q and present p reaches thr (lead or lag)
  function automatic logic jump_hit(input vjd_pkg::vjd_wcplx_t p,
                                    input vjd_pkg::vjd_wcplx_t q,
                                    input logic [15:0] thr);
    logic signed [63:0] crs;
    logic signed [63:0] dot;
    logic        [63:0] acrs;
    crs  = 64'(q.re) * 64'(p.im) - 64'(q.im) * 64'(p.re);
    dot  = 64'(q.re) * 64'(p.re) + 64'(q.im) * 64'(p.im);
    acrs = crs < 0 ? 64'(-crs) : 64'(crs);
    jump_hit = (dot <= 0) ||
      ((acrs << vjd_pkg::TAN_SHIFT) >= 64'(thr) * vjd_pkg::TAN_Q20 *
       64'(dot));
  endfunction

  // candidate vectors: three phase-earth, three phase-phase, fourth channel
  function automatic vjd_pkg::vjd_wcplx_t cand(
    input vjd_pkg::vjd_cplx_t c1, input vjd_pkg::vjd_cplx_t c2,
    input vjd_pkg::vjd_cplx_t c3, input vjd_pkg::vjd_cplx_t c4,
    input int idx);
    vjd_pkg::vjd_cplx_t a;
    vjd_pkg::vjd_cplx_t b;
    a = (idx == 0 || idx == 3) ? c1 : (idx == 1 || idx == 4) ? c2 :
        (idx == 2 || idx == 5) ? c3 : c4;
    b = (idx == 3) ? c2 : (idx == 4) ? c3 : c1;
    if (idx >= vjd_pkg::IDX_PP12 && idx < vjd_pkg::IDX_U4) begin
      cand.re = 17'(a.re) - 17'(b.re);
      cand.im = 17'(a.im) - 17'(b.im);
    end else begin
      cand.re = 17'(a.re);
      cand.im = 17'(a.im);
    end
  endfunction

  // one-cycle history per input channel, indexed by write pointer
  vjd_pkg::vjd_cplx_t hist [vjd_pkg::NUM_CH][vjd_pkg::SAMPLES_PER_CYCLE];
  logic [vjd_pkg::HIST_AW-1:0] wr_ptr;
  logic                        hist_full;
  logic [vjd_pkg::CNT_W-1:0]   trip_cnt;
  logic [vjd_pkg::CNT_W-1:0]   alarm_cnt;
  logic                        trip_run;
  logic                        alarm_run;
  logic                        blocked_run;
  logic [6:0]                  trip_hits;
  logic [6:0]                  alarm_hits;
  logic [6:0]                  uv_hits;
  logic [6:0]                  sel_mask;
  logic                        all_mode;
  logic [63:0]                 uv_ref;
  logic                        trip_pick;
  logic                        alarm_pick;
  logic                        uv_block;
  logic                        fire_trip;
  logic                        fire_alarm;
  logic                        alarm_ok;

  vjd_pkg::vjd_cplx_t past [vjd_pkg::NUM_CH];
  assign past[0] = hist[0][wr_ptr];
  assign past[1] = hist[1][wr_ptr];
  assign past[2] = hist[2][wr_ptr];
  assign past[3] = hist[3][wr_ptr];

  // channel selection from the static monitored-voltage setting
  assign all_mode = (monitored == vjd_pkg::MON_ALL_PP) ||
                    (monitored == vjd_pkg::MON_ALL_PE);
  always_comb begin
    unique case (monitored)
      vjd_pkg::MON_ALL_PP, vjd_pkg::MON_ANY_PP: sel_mask = vjd_pkg::MASK_PP;
      vjd_pkg::MON_L12: sel_mask = 7'h01 << vjd_pkg::IDX_PP12;
      vjd_pkg::MON_L23: sel_mask = 7'h02 << vjd_pkg::IDX_PP12;
      vjd_pkg::MON_L31: sel_mask = 7'h04 << vjd_pkg::IDX_PP12;
      vjd_pkg::MON_ALL_PE, vjd_pkg::MON_ANY_PE: sel_mask = vjd_pkg::MASK_PE;
      vjd_pkg::MON_L1:  sel_mask = 7'h01 << vjd_pkg::IDX_PE1;
      vjd_pkg::MON_L2:  sel_mask = 7'h02 << vjd_pkg::IDX_PE1;
      vjd_pkg::MON_L3:  sel_mask = 7'h04 << vjd_pkg::IDX_PE1;
      vjd_pkg::MON_U4:  sel_mask = 7'h01 << vjd_pkg::IDX_U4;
      default:          sel_mask = vjd_pkg::MASK_PP;
    endcase
  end

  // per-candidate complex comparisons, same thresholds for every one
  assign uv_ref = 64'(uv_limit) * 64'(nominal_voltage);
  for (genvar g = 0; g < vjd_pkg::NUM_CAND; g++) begin : g_cand
    vjd_pkg::vjd_wcplx_t now_v;
    vjd_pkg::vjd_wcplx_t old_v;
    assign now_v = cand(chan1_complex_vector, chan2_complex_vector,
                        chan3_complex_vector, chan4_complex_vector, g);
    assign old_v = cand(past[0], past[1], past[2], past[3], g);
    assign trip_hits[g]  = jump_hit(now_v, old_v, trip_threshold);
    assign alarm_hits[g] = jump_hit(now_v, old_v, alarm_threshold);
    assign uv_hits[g] = mag2(now_v) * vjd_pkg::PCT_SCALE_SQ <
                        uv_ref * uv_ref;
  end

  // all-modes need every selected hit, any-modes just one
  assign trip_pick  = hist_full && (all_mode ?
                      ((trip_hits & sel_mask) == sel_mask) :
                      |(trip_hits & sel_mask));
  assign alarm_pick = hist_full && (all_mode ?
                      ((alarm_hits & sel_mask) == sel_mask) :
                      |(alarm_hits & sel_mask));
  assign uv_block   = |(uv_hits & sel_mask);
  assign alarm_ok   = stage_avail == vjd_pkg::AV_TRIP_ALARM;
  assign fire_trip  = sample_valid && trip_pick && !uv_block &&
                      !block_in && !trip_run;
  assign fire_alarm = sample_valid && alarm_pick && alarm_ok &&
                      !uv_block && !block_in && !alarm_run;

  // history write, one slot per sample, 64 slots per cycle
  always_ff @(posedge ref_clk) begin
    if (clk_en && sample_valid) begin
      hist[0][wr_ptr] <= chan1_complex_vector;
      hist[1][wr_ptr] <= chan2_complex_vector;
      hist[2][wr_ptr] <= chan3_complex_vector;
      hist[3][wr_ptr] <= chan4_complex_vector;
    end
  end

  // pointer and fill state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr    <= '0;
      hist_full <= 1'b0;
    end else if (clk_en && sample_valid) begin
      wr_ptr <= wr_ptr + 1'b1;
      if (&wr_ptr) hist_full <= 1'b1;
    end
  end

  // the single stage: fixed-length trip pulse and optional alarm pulse
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      trip_cnt  <= '0;
      alarm_cnt <= '0;
    end else if (clk_en) begin
      if (fire_trip) trip_cnt <= vjd_pkg::CNT_W'(PULSE_LEN);
      else if (trip_cnt != '0) trip_cnt <= trip_cnt - 1'b1;
      if (fire_alarm) alarm_cnt <= vjd_pkg::CNT_W'(PULSE_LEN);
      else if (alarm_cnt != '0 && alarm_ok) alarm_cnt <= alarm_cnt - 1'b1;
      else if (!alarm_ok) alarm_cnt <= '0;
    end
  end
  assign trip_run  = trip_cnt != '0;
  assign alarm_run = alarm_cnt != '0;

  // blocked indication and faulted-channel record, per program cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      blocked_run    <= 1'b0;
      fault_channels <= '0;
    end else if (clk_en && sample_valid) begin
      blocked_run <= uv_block ||
                     (block_in && (trip_pick || alarm_pick));
      if (fire_trip || fire_alarm)
        fault_channels <= (trip_hits | alarm_hits) & sel_mask;
    end
  end

  // outputs, overridden by the forced status when forcing is enabled
  assign trip    = force_enable ? force_status == vjd_pkg::ST_TRIP :
                   trip_run;
  assign alarm   = force_enable ? force_status == vjd_pkg::ST_ALARM :
                   alarm_run;
  assign blocked = force_enable ? force_status == vjd_pkg::ST_BLOCKED :
                   blocked_run;
  assign status  = force_enable ? force_status :
                   trip_run ? vjd_pkg::ST_TRIP :
                   alarm_run ? vjd_pkg::ST_ALARM :
                   blocked_run ? vjd_pkg::ST_BLOCKED : vjd_pkg::ST_NORMAL;

  // checks on the stage behaviour
  property p_trip_start;
    @(posedge ref_clk) disable iff (reset)
      clk_en && fire_trip |=> trip_cnt == vjd_pkg::CNT_W'(PULSE_LEN);
  endproperty
  a_trip_start: assert property (p_trip_start) else $error("no trip load");

  property p_trip_end;
    @(posedge ref_clk) disable iff (reset)
      clk_en && trip_cnt == 1 && !fire_trip |=> !trip_run;
  endproperty
  a_trip_end: assert property (p_trip_end) else $error("trip stuck");

  property p_trip_cause;
    @(posedge ref_clk) disable iff (reset)
      $rose(trip_run) |-> $past(trip_pick) && !$past(block_in);
  endproperty
  a_trip_cause: assert property (p_trip_cause) else $error("bad trip");

  property p_alarm_gate;
    @(posedge ref_clk) disable iff (reset)
      $rose(alarm_run) |-> $past(alarm_ok);
  endproperty
  a_alarm_gate: assert property (p_alarm_gate) else $error("alarm off");

  property p_block_wins;
    @(posedge ref_clk) disable iff (reset)
      clk_en && sample_valid && block_in && trip_pick && !trip_run
      |=> blocked_run && !trip_run;
  endproperty
  a_block_wins: assert property (p_block_wins) else $error("not blocked");

  property p_uv_block;
    @(posedge ref_clk) disable iff (reset)
      clk_en && sample_valid && uv_block |=> blocked_run && !$rose(trip_run);
  endproperty
  a_uv_block: assert property (p_uv_block) else $error("uv miss");

  property p_force;
    @(posedge ref_clk) disable iff (reset)
      force_enable |-> status == force_status &&
      trip == (force_status == vjd_pkg::ST_TRIP);
  endproperty
  a_force: assert property (p_force) else $error("force ignored");

  property p_rate;
    @(posedge ref_clk) disable iff (reset)
      clk_en && sample_valid |=> wr_ptr == $past(wr_ptr) + 1'b1;
  endproperty
  a_rate: assert property (p_rate) else $error("pointer slip");

  property p_any_mode;
    @(posedge ref_clk) disable iff (reset)
      clk_en && sample_valid && hist_full && !all_mode && !uv_block &&
      |(trip_hits & sel_mask) && !block_in && !trip_run
      |=> trip_run && fault_channels != '0;
  endproperty
  a_any_mode: assert property (p_any_mode) else $error("any mode");

  c_trip:    cover property (@(posedge ref_clk) $rose(trip_run));
  c_alarm:   cover property (@(posedge ref_clk) $rose(alarm_run));
  c_blocked: cover property (@(posedge ref_clk) $rose(blocked_run));
  c_forced:  cover property (@(posedge ref_clk) force_enable && trip);

endmodule // vjd_detector

//--- bench/vjd_sample_source.sv
// sample source model: rotating four-channel voltage vectors with jumps
`timescale 1ns/1ps
module vjd_sample_source #(
  parameter int AMP = 10000,
  parameter int GAP = 4
) (
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic               jump_req,
  input  wire logic [3:0]         jump_mask,
  input  wire logic signed [15:0] jump_cdeg,
  output logic                    sample_valid,
  output vjd_pkg::vjd_cplx_t      chan1_complex_vector,
  output vjd_pkg::vjd_cplx_t      chan2_complex_vector,
  output vjd_pkg::vjd_cplx_t      chan3_complex_vector,
  output vjd_pkg::vjd_cplx_t      chan4_complex_vector
);
  real ofs [4] = '{0.0, -120.0, 120.0, 0.0}; // base angles l1 l2 l3 u4
  int  n       = 0;
  int  div     = 0;

  function automatic vjd_pkg::vjd_cplx_t vec(input real deg);
    vjd_pkg::vjd_cplx_t v;
    v.re = 16'(int'(AMP * $cos(deg * 3.14159265 / 180.0)));
    v.im = 16'(int'(AMP * $sin(deg * 3.14159265 / 180.0)));
    return v;
  endfunction

  // known levels before the first edge
  initial {sample_valid, chan1_complex_vector, chan2_complex_vector,
           chan3_complex_vector, chan4_complex_vector} = '0;

  // phase jumps persist; data lines toggle between samples, hold only in reset
  always @(posedge ref_clk) begin
    for (int c = 0; c < 4; c++) begin
      if (jump_req && jump_mask[c]) ofs[c] += jump_cdeg / 100.0;
    end
    if (reset) begin
      sample_valid <= 1'b0;
      div = 0;
    end else begin
      sample_valid <= (div == GAP - 1);
      if (div == GAP - 1) begin
        chan1_complex_vector <= vec(n * 5.625 + ofs[0]);
        chan2_complex_vector <= vec(n * 5.625 + ofs[1]);
        chan3_complex_vector <= vec(n * 5.625 + ofs[2]);
        chan4_complex_vector <= vec(n * 5.625 + ofs[3]);
        n = n + 1;
      end else begin
        chan1_complex_vector <= ~chan1_complex_vector;
        chan2_complex_vector <= ~chan2_complex_vector;
        chan3_complex_vector <= ~chan3_complex_vector;
        chan4_complex_vector <= ~chan4_complex_vector;
      end
      div = (div + 1) % GAP;
    end
  end
endmodule // vjd_sample_source

//--- bench/vjd_detector_test.sv
// testbench: phase jump scenarios against the vector jump detector
`timescale 1ns/1ps
module vjd_detector_test;
  localparam int PLEN = 20;
  logic                    ref_clk, reset, clk_en, sample_valid;
  logic                    block_in, force_enable, jump_req;
  logic [3:0]              jump_mask;
  logic signed [15:0]      jump_cdeg;
  logic [15:0]             nominal_voltage, trip_threshold, alarm_threshold;
  logic [13:0]             uv_limit;
  logic                    trip, alarm, blocked;
  logic [6:0]              fault_channels;
  vjd_pkg::vjd_cplx_t      c1, c2, c3, c4;
  vjd_pkg::vjd_status_t    force_status, status;
  vjd_pkg::vjd_avail_t     stage_avail;
  vjd_pkg::vjd_mon_t       monitored;
  int                      n_fail, num_checks;

  vjd_sample_source SRC (.ref_clk(ref_clk), .reset(reset),
    .jump_req(jump_req), .jump_mask(jump_mask), .jump_cdeg(jump_cdeg),
    .sample_valid(sample_valid), .chan1_complex_vector(c1),
    .chan2_complex_vector(c2), .chan3_complex_vector(c3),
    .chan4_complex_vector(c4));

  vjd_detector #(.PULSE_LEN(PLEN)) DUT (.ref_clk(ref_clk), .reset(reset),
    .clk_en(clk_en), .sample_valid(sample_valid),
    .chan1_complex_vector(c1), .chan2_complex_vector(c2),
    .chan3_complex_vector(c3), .chan4_complex_vector(c4),
    .nominal_voltage(nominal_voltage), .trip_threshold(trip_threshold),
    .alarm_threshold(alarm_threshold), .uv_limit(uv_limit),
    .block_in(block_in), .force_enable(force_enable),
    .force_status(force_status), .stage_avail(stage_avail),
    .monitored(monitored), .trip(trip), .alarm(alarm), .blocked(blocked),
    .status(status), .fault_channels(fault_channels));

  // clock at 100 mhz
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one jump, watch for pick-up, time the trip pulse, then let history flush
  task automatic jump(input string name, input logic [3:0] mask,
                      input int cdeg, input logic et, input logic ea,
                      input logic eb, input int fbit);
    logic t, a, b;
    int   len;
    t = 0; a = 0; b = 0; len = 0;
    @(posedge ref_clk);
    jump_mask <= mask;
    jump_cdeg <= 16'(cdeg);
    jump_req  <= 1'b1;
    @(posedge ref_clk);
    jump_req <= 1'b0;
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      a = a | (alarm === 1'b1);
      b = b | (blocked === 1'b1);
      if (trip === 1'b1 && !t) begin
        t = 1;
        if (fbit >= 0) check({name, " fault"}, 16'(fault_channels[fbit]),
                             16'h0001);
        check({name, " status"}, 16'(status), 16'(vjd_pkg::ST_TRIP));
        while (trip === 1'b1) begin
          len++;
          if (len > 100) begin
            n_fail++;
            conclude();
          end
          @(posedge ref_clk);
          #1;
        end
        check({name, " pulse"}, 16'(len), 16'(PLEN));
      end
    end
    check({name, " trip"}, 16'(t), 16'(et));
    check({name, " alarm"}, 16'(a), 16'(ea));
    check({name, " blocked"}, 16'(b), 16'(eb));
    repeat (320) @(posedge ref_clk);
    $display("test %s done", name);
  endtask

  initial begin
    n_fail = 0; num_checks = 0;
    reset = 1'b1; clk_en = 1'b1; block_in = 1'b0; force_enable = 1'b0;
    jump_req = 1'b0; jump_mask = 4'h0; jump_cdeg = 16'h0000;
    nominal_voltage = 16'h2710; trip_threshold = vjd_pkg::THR_DEFAULT;
    alarm_threshold = vjd_pkg::THR_DEFAULT; uv_limit = vjd_pkg::UV_DEFAULT;
    force_status = vjd_pkg::ST_NORMAL; stage_avail = vjd_pkg::AV_TRIP;
    monitored = vjd_pkg::MON_ANY_PP;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    check("reset out", {trip, alarm, blocked, status, fault_channels},
          16'h0000);
    repeat (300) @(posedge ref_clk);
    jump("quiet", 4'h7, 0, 0, 0, 0, -1);
    jump("lead10", 4'h7, 1000, 1, 0, 0, 3);
    jump("lead4", 4'h7, 400, 0, 0, 0, -1);
    jump("lag10", 4'h7, -1000, 1, 0, 0, 4);
    stage_avail <= vjd_pkg::AV_TRIP_ALARM;
    trip_threshold <= 16'h07d0;
    alarm_threshold <= 16'h012c;
    jump("alarm5", 4'h7, 500, 0, 1, 0, -1);
    stage_avail <= vjd_pkg::AV_TRIP;
    jump("noalarm", 4'h7, 500, 0, 0, 0, -1);
    trip_threshold <= vjd_pkg::THR_DEFAULT;
    monitored <= vjd_pkg::MON_U4;
    jump("u4 ch1", 4'h1, 1000, 0, 0, 0, -1);
    jump("u4 ch4", 4'h8, 1000, 1, 0, 0, 6);
    monitored <= vjd_pkg::MON_ALL_PE;
    jump("allpe", 4'h1, 1000, 0, 0, 0, -1);
    monitored <= vjd_pkg::MON_ANY_PE;
    jump("anype", 4'h1, 1000, 1, 0, 0, 0);
    block_in <= 1'b1; // raised a few clocks before the jump and pick-up
    jump("blockin", 4'h7, 1000, 0, 0, 1, -1);
    block_in <= 1'b0;
    nominal_voltage <= 16'h2ee0;
    jump("undervolt", 4'h7, 1000, 0, 0, 1, -1);
    nominal_voltage <= 16'h2710;
    force_status <= vjd_pkg::ST_TRIP;
    repeat (8) @(posedge ref_clk);
    #1;
    check("force off", 16'(status), 16'(vjd_pkg::ST_NORMAL));
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      force_enable <= 1'b1;
      force_status <= vjd_pkg::vjd_status_t'(i);
      repeat (2) @(posedge ref_clk);
      #1;
      check("forced status", 16'(status), 16'(i));
      check("forced trip", 16'(trip), 16'(i == 2));
      check("forced block", 16'(blocked), 16'(i == 1));
      check("forced alarm", 16'(alarm), 16'(i == 3));
    end
    $display("test force done");
    conclude();
  end
endmodule // vjd_detector_test
